// ### include/lbp_pkg.sv
// package of constants, types and helpers for the led blink pattern engine
package lbp_pkg;

  // clock and time base
  localparam int unsigned CLK_NS        = 25;
  localparam int unsigned TICK_US       = 16384;
  localparam int unsigned TICK_CYC      = (TICK_US * 1000) / CLK_NS;
  localparam int unsigned RAMP_TICK_NS  = 2048;
  localparam int unsigned RAMP_CYC      = (RAMP_TICK_NS + CLK_NS - 1) / CLK_NS;

  // duration code segments, counted in ticks
  localparam logic [7:0]  SEG1_LAST     = 8'h3c;
  localparam logic [7:0]  SEG2_LAST     = 8'h7f;
  localparam logic [12:0] SEG1_TICKS    = 13'h003d;
  localparam logic [12:0] SEG2_TICKS    = 13'h0255;
  localparam logic [12:0] SEG2_STEP     = 13'h0008;
  localparam logic [12:0] SEG3_STEP     = 13'h0020;

  // ambient zone decision
  localparam logic [5:0]  RUN_NEED      = 6'h03;
  localparam logic [5:0]  DOWN_BASE     = 6'h06;
  localparam logic [2:0]  ZONE_LAST     = 3'h4;
  localparam int unsigned NUM_BANKS     = 4;
  localparam int unsigned NUM_ZONES     = 5;

  // register map, global
  localparam logic [7:0]  OFF_AMB_CFG   = 8'h00;
  localparam logic [7:0]  OFF_DOWN_DLY  = 8'h01;
  localparam logic [7:0]  OFF_ZONE_INFO = 8'h02;
  localparam logic [7:0]  OFF_STATUS    = 8'h03;
  localparam logic [7:0]  OFF_SCALE0    = 8'h08;
  // register map, per bank: base + 8 * bank + field
  localparam logic [2:0]  BANK_BASE_HI  = 3'h1;
  localparam logic [2:0]  FLD_CFG       = 3'h0;
  localparam logic [2:0]  FLD_UPPER     = 3'h1;
  localparam logic [2:0]  FLD_LOWER     = 3'h2;
  localparam logic [2:0]  FLD_DELAY     = 3'h3;
  localparam logic [2:0]  FLD_RISE      = 3'h4;
  localparam logic [2:0]  FLD_FALL      = 3'h5;
  localparam logic [2:0]  FLD_HIGH      = 3'h6;
  localparam logic [2:0]  FLD_LOW       = 3'h7;

  // field positions
  localparam int unsigned CFG_DUTY_BIT  = 0;
  localparam int unsigned CFG_EXP_BIT   = 1;
  localparam int unsigned CFG_AMB_BIT   = 2;
  localparam int unsigned CFG_PAT_BIT   = 3;
  localparam int unsigned AMB_EN_BIT    = 0;
  localparam int unsigned INT_MODE_BIT  = 0;

  // reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [3:0]  RST_SCALE     = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_RISE  = 3'b010,
    ST_HIGH  = 3'b011,
    ST_FALL  = 3'b100,
    ST_LOW   = 3'b101
  } lbp_state_t;

  typedef enum logic [1:0] {
    ALG_DIRECT     = 2'b00,
    ALG_UP_ONLY    = 2'b01,
    ALG_DOWN_DELAY = 2'b10
  } lbp_alg_t;

  // duration code to tick count: 1, 8 or 32 ticks per step by segment
  function automatic logic [12:0] code_ticks(input logic [7:0] code);
    if (code <= SEG1_LAST) begin
      return 13'(code) + 13'h0001;
    end else if (code <= SEG2_LAST) begin
      return SEG1_TICKS + 13'(code - SEG1_LAST) * SEG2_STEP;
    end else begin
      return SEG2_TICKS + 13'(code - SEG2_LAST) * SEG3_STEP;
    end
  endfunction

endpackage

// ### logic/lbp_gen.sv
// one pattern generator: delay, rise, high hold, fall, low hold
`timescale 1ns/1ps
`default_nettype none
module lbp_gen #(
  parameter int unsigned TICK_CYCLES = lbp_pkg::TICK_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                start,
  input  wire logic                enable,
  input  wire logic                ramp_tick,
  input  wire logic [12:0]         delay_ticks,
  input  wire logic [12:0]         high_ticks,
  input  wire logic [12:0]         low_ticks,
  input  wire logic [2:0]          rise_code,
  input  wire logic [2:0]          fall_code,
  input  wire logic [7:0]          hi_level,
  input  wire logic [7:0]          lo_level,
  output lbp_pkg::lbp_state_t      state,
  output logic      [7:0]          level
);
  import lbp_pkg::*;

  logic [19:0] pre;
  logic        tick;
  logic [12:0] tcnt;
  logic [7:0]  rcnt;
  logic [7:0]  rlim;
  logic        step;

  // private prescaler, restarted at start and held clear outside timed states
  // so every delay and hold lasts whole ticks from its own entry
  assign tick = (pre == 20'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || start || tick || state == ST_IDLE || state == ST_RISE || state == ST_FALL) begin
      pre <= '0;
    end else begin
      pre <= pre + 20'h00001;
    end
  end

  // ramp step: one code step every 2^setting ramp ticks
  assign rlim = (8'h01 << ((state == ST_FALL) ? fall_code : rise_code)) - 8'h01;
  assign step = ramp_tick && (rcnt == rlim);

  always_ff @(posedge clk) begin
    if (!rst_n || !(state == ST_RISE || state == ST_FALL) || step) begin
      rcnt <= '0;
    end else if (ramp_tick) begin
      rcnt <= rcnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tcnt  <= '0;
      level <= '0;
    end else if (start) begin
      // start comes with the enabling write, before the enable bit is stored
      state <= ST_DELAY;
      tcnt  <= '0;
      level <= lo_level;
    end else if (!enable) begin
      state <= ST_IDLE;
      tcnt  <= '0;
      level <= lo_level;
    end else begin
      case (state)
        ST_DELAY: begin
          level <= lo_level;
          if (tick) begin
            if (tcnt == delay_ticks - 13'h0001) begin
              state <= ST_RISE;
              tcnt  <= '0;
            end else begin
              tcnt <= tcnt + 13'h0001;
            end
          end
        end
        ST_RISE: begin
          if (level >= hi_level) begin
            state <= ST_HIGH;
            level <= hi_level;
          end else if (step) begin
            level <= level + 8'h01;
          end
        end
        ST_HIGH: begin
          level <= hi_level;
          if (tick) begin
            if (tcnt == high_ticks - 13'h0001) begin
              state <= ST_FALL;
              tcnt  <= '0;
            end else begin
              tcnt <= tcnt + 13'h0001;
            end
          end
        end
        ST_FALL: begin
          if (level <= lo_level) begin
            state <= ST_LOW;
            level <= lo_level;
          end else if (step) begin
            level <= level - 8'h01;
          end
        end
        ST_LOW: begin
          level <= lo_level;
          if (tick) begin
            if (tcnt == low_ticks - 13'h0001) begin
              state <= ST_RISE;
              tcnt  <= '0;
            end else begin
              tcnt <= tcnt + 13'h0001;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          level <= lo_level;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### logic/lbp_top.sv
// led blink pattern engine: registers, ambient zone logic, four generators
//
// Behaviour
// - four generators, each with own registers
// - setting config bit 3 starts pattern delay
// - ramp up only after start delay expires
// - delay code maps piecewise linear, two segments
// - rise ramp speed from eight settings
// - fall ramp speed from eight settings
// - high hold uses two-segment code
// - low hold uses three-segment code
// - low code, linear mapping, duty optional
// - low code, exponential mapping, duty optional
// - high code, linear mapping, duty optional
// - high code, exponential mapping, duty optional
// - levels follow zone decision algorithms
// - zone scale factor multiplies codes, sixteen levels
// - one scale set shared by all generators
// - disabled pattern uses mappers, enabled uses scalers
// - zone info bit 0 selects interrupt mode
// - interrupt pulls low on zone change
// - reading zone info releases interrupt
// - down delay adds three to thirty-four periods
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lbp_top #(
  parameter int unsigned TICK_CYCLES = lbp_pkg::TICK_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic [2:0]          ambient_light_input_zone,
  input  wire logic                ambient_light_input_period,
  input  wire logic                int_pin_in,
  output logic                     int_pin_out,
  output logic                     int_pin_oe_n,
  output logic      [3:0][7:0]     bank_level,
  output logic      [3:0]          bank_exp_map,
  output logic      [3:0]          bank_duty_en,
  output logic      [3:0]          bank_pattern_on,
  output logic      [3:0]          bank_zone_mapper,
  output logic      [3:0]          bank_zone_scaler,
  output logic      [2:0]          amb_target_zone
);
  import lbp_pkg::*;

  // per-bank programming registers
  logic [7:0]  cfg       [NUM_BANKS];
  logic [7:0]  upper_level_code [NUM_BANKS];
  logic [7:0]  lower_level_code [NUM_BANKS];
  logic [6:0]  dly_code  [NUM_BANKS];
  logic [2:0]  rise_code [NUM_BANKS];
  logic [2:0]  fall_code [NUM_BANKS];
  logic [6:0]  high_code [NUM_BANKS];
  logic [7:0]  low_code  [NUM_BANKS];
  // global registers
  logic [7:0]  amb_cfg;
  logic [4:0]  down_code;
  logic        int_mode;
  logic [3:0]  scale     [NUM_ZONES];

  logic        amb_en;
  lbp_alg_t    alg;
  logic        bank_hit;
  logic [1:0]  bank_sel;
  logic [2:0]  fld;
  logic        zone_read;

  logic [2:0]  last_zone;
  logic [5:0]  run_cnt;
  logic        run_up;
  logic        up_dir;
  logic [5:0]  need;
  logic        zone_event;
  logic        int_flag;

  logic [9:0]  ramp_pre;
  logic        ramp_tick;
  logic        pin_s1;
  logic        pin_s2;
  logic        pin_s3;
  logic        pin_level;

  logic [3:0]  start;
  logic [3:0]  scaler_on;
  logic [3:0]  cur_scale;
  lbp_state_t  gen_state [NUM_BANKS];
  logic [7:0]  gen_level [NUM_BANKS];
  logic [7:0]  gen_hi    [NUM_BANKS];
  logic [7:0]  gen_lo    [NUM_BANKS];

  // code times zone factor over sixteen
  function automatic logic [7:0] scale_code(input logic [7:0] code, input logic [3:0] s);
    logic [12:0] p;
    p = 13'(code) * 13'({1'b0, s} + 5'h01);
    return p[11:4];
  endfunction

  // address decode for the bank window
  assign bank_hit  = (reg_addr[7:5] == BANK_BASE_HI);
  assign bank_sel  = reg_addr[4:3];
  assign fld       = reg_addr[2:0];
  assign zone_read = reg_rd && (reg_addr == OFF_ZONE_INFO);
  assign amb_en    = amb_cfg[AMB_EN_BIT];
  assign alg       = lbp_alg_t'(amb_cfg[2:1]);

  // register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      amb_cfg   <= RST_BYTE;
      down_code <= '0;
      int_mode  <= 1'b0;
      for (int z = 0; z < NUM_ZONES; z++) begin
        scale[z] <= RST_SCALE;
      end
    end else if (reg_wr) begin
      if (reg_addr == OFF_AMB_CFG) begin
        amb_cfg <= reg_wdata;
      end else if (reg_addr == OFF_DOWN_DLY) begin
        down_code <= reg_wdata[4:0];
      end else if (reg_addr == OFF_ZONE_INFO) begin
        int_mode <= reg_wdata[INT_MODE_BIT];
      end else if (reg_addr >= OFF_SCALE0 && reg_addr < OFF_SCALE0 + 8'(NUM_ZONES)) begin
        scale[3'(reg_addr - OFF_SCALE0)] <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        cfg[b]              <= RST_BYTE;
        upper_level_code[b] <= RST_BYTE;
        lower_level_code[b] <= RST_BYTE;
        dly_code[b]         <= '0;
        rise_code[b]        <= '0;
        fall_code[b]        <= '0;
        high_code[b]        <= '0;
        low_code[b]         <= RST_BYTE;
      end
    end else if (reg_wr && bank_hit) begin
      if (fld == FLD_CFG) begin
        cfg[bank_sel] <= reg_wdata;
      end else if (fld == FLD_UPPER) begin
        upper_level_code[bank_sel] <= reg_wdata;
      end else if (fld == FLD_LOWER) begin
        lower_level_code[bank_sel] <= reg_wdata;
      end else if (fld == FLD_DELAY) begin
        dly_code[bank_sel] <= reg_wdata[6:0];
      end else if (fld == FLD_RISE) begin
        rise_code[bank_sel] <= reg_wdata[2:0];
      end else if (fld == FLD_FALL) begin
        fall_code[bank_sel] <= reg_wdata[2:0];
      end else if (fld == FLD_HIGH) begin
        high_code[bank_sel] <= reg_wdata[6:0];
      end else begin
        low_code[bank_sel] <= reg_wdata;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == OFF_AMB_CFG) begin
        reg_rdata <= amb_cfg;
      end else if (reg_addr == OFF_DOWN_DLY) begin
        reg_rdata <= {3'h0, down_code};
      end else if (reg_addr == OFF_ZONE_INFO) begin
        reg_rdata <= {int_flag, ambient_light_input_zone, amb_target_zone, int_mode};
      end else if (reg_addr == OFF_STATUS) begin
        reg_rdata <= {3'h0, pin_level, bank_pattern_on};
      end else if (reg_addr >= OFF_SCALE0 && reg_addr < OFF_SCALE0 + 8'(NUM_ZONES)) begin
        reg_rdata <= {4'h0, scale[3'(reg_addr - OFF_SCALE0)]};
      end else if (bank_hit) begin
        if (fld == FLD_CFG) begin
          reg_rdata <= cfg[bank_sel];
        end else if (fld == FLD_UPPER) begin
          reg_rdata <= upper_level_code[bank_sel];
        end else if (fld == FLD_LOWER) begin
          reg_rdata <= lower_level_code[bank_sel];
        end else if (fld == FLD_DELAY) begin
          reg_rdata <= {1'b0, dly_code[bank_sel]};
        end else if (fld == FLD_RISE) begin
          reg_rdata <= {5'h00, rise_code[bank_sel]};
        end else if (fld == FLD_FALL) begin
          reg_rdata <= {5'h00, fall_code[bank_sel]};
        end else if (fld == FLD_HIGH) begin
          reg_rdata <= {1'b0, high_code[bank_sel]};
        end else begin
          reg_rdata <= low_code[bank_sel];
        end
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // zone decision: direct, up-only, down-delay
  assign up_dir = (ambient_light_input_zone > amb_target_zone);
  assign need   = (!up_dir && alg == ALG_DOWN_DELAY) ? DOWN_BASE + {1'b0, down_code} : RUN_NEED;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      amb_target_zone <= '0;
      run_cnt         <= '0;
      run_up          <= 1'b0;
    end else if (!amb_en) begin
      run_cnt <= '0;
    end else if (ambient_light_input_period) begin
      if (ambient_light_input_zone == amb_target_zone || (alg == ALG_UP_ONLY && !up_dir)) begin
        run_cnt <= '0;
      end else if (run_cnt != 6'h00 && run_up != up_dir) begin
        run_cnt <= 6'h01;
        run_up  <= up_dir;
      end else if (run_cnt + 6'h01 >= need) begin
        amb_target_zone <= ambient_light_input_zone;
        run_cnt         <= '0;
      end else begin
        run_cnt <= run_cnt + 6'h01;
        run_up  <= up_dir;
      end
    end
  end

  // interrupt on any zone change of the averaged input while amb_en is set
  assign zone_event = amb_en && ambient_light_input_period && (ambient_light_input_zone != last_zone);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_zone <= '0;
    end else if (ambient_light_input_period) begin
      last_zone <= ambient_light_input_zone;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_flag <= 1'b0;
    end else if (zone_event) begin
      int_flag <= 1'b1;
    end else if (zone_read) begin
      int_flag <= 1'b0;
    end
  end

  assign int_pin_out  = 1'b0;
  assign int_pin_oe_n = !(int_mode && int_flag);

  // pin level seen back from the wire
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1    <= 1'b1;
      pin_s2    <= 1'b1;
      pin_s3    <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      pin_s1 <= int_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  // shared ramp step rate
  assign ramp_tick = (ramp_pre == 10'(RAMP_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || ramp_tick) begin
      ramp_pre <= '0;
    end else begin
      ramp_pre <= ramp_pre + 10'h001;
    end
  end

  assign cur_scale = (amb_target_zone > ZONE_LAST) ? RST_SCALE : scale[amb_target_zone];

  // per-bank generators and level selection
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    assign start[b] = reg_wr && bank_hit && (bank_sel == 2'(b)) && (fld == FLD_CFG)
                      && reg_wdata[CFG_PAT_BIT] && !cfg[b][CFG_PAT_BIT];
    assign scaler_on[b] = amb_en && cfg[b][CFG_AMB_BIT];
    assign gen_hi[b] = scaler_on[b] ? scale_code(upper_level_code[b], cur_scale)
                                    : upper_level_code[b];
    assign gen_lo[b] = scaler_on[b] ? scale_code(lower_level_code[b], cur_scale)
                                    : lower_level_code[b];

    lbp_gen #(
      .TICK_CYCLES (TICK_CYCLES)
    ) i_lbp_gen (
      .clk         (clk),
      .rst_n       (rst_n),
      .start       (start[b]),
      .enable      (cfg[b][CFG_PAT_BIT]),
      .ramp_tick   (ramp_tick),
      .delay_ticks (code_ticks({1'b0, dly_code[b]})),
      .high_ticks  (code_ticks({1'b0, high_code[b]})),
      .low_ticks   (code_ticks(low_code[b])),
      .rise_code   (rise_code[b]),
      .fall_code   (fall_code[b]),
      .hi_level    (gen_hi[b]),
      .lo_level    (gen_lo[b]),
      .state       (gen_state[b]),
      .level       (gen_level[b])
    );

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        bank_level[b]       <= '0;
        bank_exp_map[b]     <= 1'b0;
        bank_duty_en[b]     <= 1'b0;
        bank_pattern_on[b]  <= 1'b0;
        bank_zone_mapper[b] <= 1'b0;
        bank_zone_scaler[b] <= 1'b0;
      end else begin
        // idle banks fall back to normal brightness control
        bank_level[b]       <= (gen_state[b] == ST_IDLE) ? upper_level_code[b] : gen_level[b];
        bank_exp_map[b]     <= cfg[b][CFG_EXP_BIT];
        bank_duty_en[b]     <= cfg[b][CFG_DUTY_BIT];
        bank_pattern_on[b]  <= (gen_state[b] != ST_IDLE);
        bank_zone_mapper[b] <= scaler_on[b] && !cfg[b][CFG_PAT_BIT];
        bank_zone_scaler[b] <= scaler_on[b] && cfg[b][CFG_PAT_BIT];
      end
    end
  end

endmodule
`default_nettype wire

// ### verif/lbp_amb_model.sv
// ambient sensor side: averaged zone, period pulses, pulled-up interrupt wire
`timescale 1ns/1ps
`default_nettype none
module lbp_amb_model #(
  parameter int unsigned PERIOD = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] zone_req,
  input  wire logic       oe_n,
  output logic      [2:0] zone,
  output logic            period,
  output logic            int_wire
);
  int cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt <= 0;
      period <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      period <= (cnt == PERIOD - 1);
    end
  end
  always_ff @(posedge clk) begin
    zone <= rst_n ? zone_req : 3'h0;
  end
  // pull-up wins when nobody pulls
  assign int_wire = oe_n ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// ### verif/lbp_top_sva.sv
// port checker for the pattern engine
`timescale 1ns/1ps
`default_nettype none
module lbp_top_sva #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [2:0] ambient_light_input_zone,
  input wire logic       ambient_light_input_period,
  input wire logic       int_pin_out,
  input wire logic       int_pin_oe_n,
  input wire logic [3:0] bank_pattern_on,
  input wire logic [3:0] bank_zone_mapper,
  input wire logic [3:0] bank_zone_scaler,
  input wire logic [2:0] amb_target_zone
);
  import lbp_pkg::*;
  logic       int_mode;
  logic       amb_en;
  logic [2:0] last_zone;
  logic       zone_evt;
  assign zone_evt = ambient_light_input_period && amb_en && (ambient_light_input_zone != last_zone);
  always_ff @(posedge clk) begin
    if (!rst_n) int_mode <= 1'b0;
    else if (reg_wr && reg_addr == OFF_ZONE_INFO) int_mode <= reg_wdata[INT_MODE_BIT];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) amb_en <= 1'b0;
    else if (reg_wr && reg_addr == OFF_AMB_CFG) amb_en <= reg_wdata[AMB_EN_BIT];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) last_zone <= 3'h0;
    else if (ambient_light_input_period) last_zone <= ambient_light_input_zone;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_evt;
    zone_evt && int_mode;
  endsequence
  sequence s_ack;
    reg_rd && reg_addr == OFF_ZONE_INFO && !zone_evt;
  endsequence
  AST_OPEN_DRAIN: assert property (int_pin_out == 1'b0)
    else $error("interrupt pin driven high");
  AST_QUIET_MODE: assert property (!int_mode |-> int_pin_oe_n)
    else $error("interrupt pulled outside interrupt mode");
  AST_INT_PULL: assert property (s_evt |=> !int_pin_oe_n)
    else $error("zone change did not pull interrupt");
  AST_INT_ACK: assert property (s_ack |=> int_pin_oe_n)
    else $error("zone info read did not release interrupt");
  AST_TARGET_HOLD: assert property (ambient_light_input_period
    && ambient_light_input_zone == amb_target_zone |=> $stable(amb_target_zone))
    else $error("target moved with no zone change");
  AST_TARGET_CAUSE: assert property ($changed(amb_target_zone) && $past(rst_n)
    |-> $past(ambient_light_input_period))
    else $error("target moved without a period");
  AST_EXCLUSIVE: assert property ((bank_zone_mapper & bank_zone_scaler) == 4'h0)
    else $error("mapper and scaler both selected");
  for (genvar b = 0; b < 4; b++) begin : g_bank
    logic cfg_wr;
    assign cfg_wr = reg_wr && reg_addr == {BANK_BASE_HI, 2'(b), FLD_CFG};
    AST_START: assert property (cfg_wr && reg_wdata[CFG_PAT_BIT]
      && !bank_pattern_on[b] |=> ##1 bank_pattern_on[b])
      else $error("pattern did not start");
    // stored enable, then idle state, then the registered flag
    AST_STOP: assert property (cfg_wr && !reg_wdata[CFG_PAT_BIT] |=> ##2 !bank_pattern_on[b])
      else $error("pattern did not stop");
  end
endmodule
bind lbp_top lbp_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_lbp_top_sva (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .ambient_light_input_zone(ambient_light_input_zone), .ambient_light_input_period(ambient_light_input_period),
  .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n), .bank_pattern_on(bank_pattern_on),
  .bank_zone_mapper(bank_zone_mapper), .bank_zone_scaler(bank_zone_scaler), .amb_target_zone(amb_target_zone));
`default_nettype wire

// ### verif/test_led_blink_pattern_engine.sv
// self-checking bench for the pattern engine
`timescale 1ns/1ps
`default_nettype none
module test_led_blink_pattern_engine;
  import lbp_pkg::*;
  localparam int TK = 20;
  logic            clk, rst_n, reg_wr, reg_rd, amb_period, run, int_wire, int_out, int_oe_n;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata;
  logic [2:0]      amb_zone, zone_req, target;
  logic [3:0][7:0] lvl;
  logic [3:0]      exp_map, duty, pat_on, mapper, scaler;
  int              bad_count, compares;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  lbp_top #(.TICK_CYCLES(TK)) i_lbp_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ambient_light_input_zone(amb_zone), .ambient_light_input_period(amb_period), .int_pin_in(int_wire),
    .int_pin_out(int_out), .int_pin_oe_n(int_oe_n), .bank_level(lvl), .bank_exp_map(exp_map),
    .bank_duty_en(duty), .bank_pattern_on(pat_on), .bank_zone_mapper(mapper),
    .bank_zone_scaler(scaler), .amb_target_zone(target));
  lbp_amb_model i_lbp_amb_model (.clk(clk), .rst_n(rst_n), .run(run), .zone_req(zone_req),
    .oe_n(int_oe_n), .zone(amb_zone), .period(amb_period), .int_wire(int_wire));

  task chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata === e, "read data differs");
  endtask
  task wait_lvl(input int b, input logic [7:0] v, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      if (lvl[b] === v) break;
    end
    if (n >= lim) begin
      chk(1'b0, "level wait timed out");
      conclude();
    end
  endtask

  task t_regs;
    chk(int_oe_n === 1'b1, "interrupt pulled after reset");
    rd(OFF_SCALE0, 8'h0f);
    rd(8'h0c, 8'h0f);
    rd(8'h10, 8'h00);
    wr(8'h21, 8'h55);
    rd(8'h21, 8'h55);
    rd(8'h29, 8'h00);
    wr(8'h30, 8'h03);
    rd(8'h30, 8'h03);
    chk(exp_map === 4'b0100 && duty === 4'b0100, "mapping flags differ");
  endtask
  task t_pattern;
    int n;
    wr(8'h21, 8'h04); wr(8'h22, 8'h02); wr(8'h26, 8'h04); wr(8'h27, 8'h04); wr(8'h20, 8'h08);
    wait_lvl(0, 8'h03, 2000, n);
    chk(n >= TK, "ramp before delay ended");
    chk(pat_on === 4'b0001, "other bank started");
    wait_lvl(0, 8'h04, 2 * RAMP_CYC, n);
    chk(n >= RAMP_CYC - 2 && n <= RAMP_CYC + 2, "rise step rate");
    // holds of five ticks outlast one ramp step
    wait_lvl(0, 8'h02, 5 * TK + 4 * RAMP_CYC, n);
    chk(n >= 5 * TK + RAMP_CYC, "fall before high hold");
    wait_lvl(0, 8'h03, TK + 3 * RAMP_CYC, n);
    chk(n >= 5 * TK, "rise before low hold");
    wr(8'h20, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk(lvl[0] === 8'h04 && pat_on[0] === 1'b0, "stop keeps running");
  endtask
  task t_rate;
    int n;
    wr(8'h24, 8'h03); wr(8'h25, 8'h01); wr(8'h20, 8'h08);
    wait_lvl(0, 8'h03, 4000, n);
    wait_lvl(0, 8'h04, 8 * RAMP_CYC + 20, n);
    chk(n >= 8 * RAMP_CYC - 2 && n <= 8 * RAMP_CYC + 2, "slow rise rate");
    wait_lvl(0, 8'h03, TK + 4 * RAMP_CYC, n);
    wait_lvl(0, 8'h02, 4 * RAMP_CYC, n);
    chk(n >= 2 * RAMP_CYC - 2 && n <= 2 * RAMP_CYC + 2, "slow fall rate");
    wr(8'h20, 8'h00);
  endtask
  task t_delay;
    int n;
    int ticks;
    // code 0x3d: 61 short ticks then one 8-tick step
    ticks = 69;
    wr(8'h31, 8'h12); wr(8'h32, 8'h10); wr(8'h33, 8'h3d); wr(8'h30, 8'h08);
    wait_lvl(2, 8'h11, ticks * TK + 400, n);
    chk(n >= ticks * TK - 2 && n <= ticks * TK + 2 * RAMP_CYC + 4, "long delay length");
    wr(8'h30, 8'h00);
  endtask
  task t_zone;
    int n;
    wr(OFF_AMB_CFG, 8'h01); wr(OFF_ZONE_INFO, 8'h01); wr(8'h0a, 8'h07);
    wr(8'h39, 8'h40); wr(8'h3a, 8'h40); wr(8'h38, 8'h04);
    wr(8'h29, 8'h40); wr(8'h2a, 8'h40);
    @(posedge clk);
    #1;
    chk(mapper[3] === 1'b1 && scaler[3] === 1'b0, "mapper not chosen");
    wr(8'h38, 8'h0c); wr(8'h28, 8'h0c);
    zone_req <= 3'h2;
    run <= 1'b1;
    repeat (64) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(target === 3'h2, "zone not applied");
    chk(int_oe_n === 1'b0 && int_wire === 1'b0 && int_out === 1'b0, "no interrupt on zone change");
    chk(scaler[3] === 1'b1 && mapper[3] === 1'b0, "scaler not chosen");
    rd(OFF_ZONE_INFO, 8'ha5);
    chk(int_oe_n === 1'b1 && int_wire === 1'b1, "read kept interrupt");
    wait_lvl(3, 8'h20, 4000, n);
    chk(lvl[1] === 8'h20, "shared scale not applied");
  endtask

  initial begin
    rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    zone_req = 3'h0; run = 1'b0; bad_count = 0; compares = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_pattern();
    t_rate();
    t_delay();
    t_zone();
    conclude();
  end
  initial begin
    repeat (100000) @(posedge clk);
    chk(1'b0, "run too long");
    conclude();
  end
endmodule
`default_nettype wire
